/* File: design/acvs_params.svh */
// Constants for the converter I2C slave: addresses, field positions and times.
// Included by the design module only; holds definitions only.
`ifndef ACVS_PARAMS_SVH
`define ACVS_PARAMS_SVH

// Fixed device address and the global synchronising address
`define ACVS_DEV_ADDR      7'h14
`define ACVS_GCALL_ADDR    7'h77

// Field positions
`define ACVS_RW_BIT        0
`define ACVS_RATE_BIT      0
`define ACVS_MSB           15

// Reset value of the rate and the full-scale clamp code
`define ACVS_RATE_RST      1'b0
`define ACVS_FULL_CODE     16'hFFFF

// Times in nanoseconds and the periods of both clocks
`define ACVS_CORE_NS       40
`define ACVS_OSC_NS        80
`define ACVS_POR_NS        500000
`define ACVS_CONV60_NS     16600000
`define ACVS_CONV30_NS     33200000

// Cycle counts derived from the times above
`define ACVS_POR_CYC       ((`ACVS_POR_NS + `ACVS_CORE_NS - 1) / `ACVS_CORE_NS)
`define ACVS_CONV60_CYC    (`ACVS_CONV60_NS / `ACVS_OSC_NS)
`define ACVS_CONV30_CYC    (`ACVS_CONV30_NS / `ACVS_OSC_NS)

`endif

/* File: design/acvs_pkg.sv */
// Types shared by the converter I2C slave.
// Assumes nothing beyond a SystemVerilog compiler.
package acvs_pkg;

  // Converter cycle phase
  typedef enum logic [1:0] {
    PH_POR,
    PH_CONV,
    PH_SLEEP,
    PH_IO
  } acvs_phase_t;

  // Serial bus position
  typedef enum logic [2:0] {
    BS_IDLE,
    BS_ADDR,
    BS_AACK,
    BS_TX,
    BS_TACK,
    BS_RX,
    BS_RACK,
    BS_IGN
  } acvs_bus_t;

  // Request that crosses into the oscillator domain
  typedef struct packed {
    logic tgl;
    logic slow;
  } acvs_conv_req_t;

  // Core domain state
  typedef struct packed {
    logic           scl_m;
    logic           scl_s;
    logic           scl_d;
    logic           sda_m;
    logic           sda_s;
    logic           sda_d;
    logic           done_m;
    logic           done_s;
    logic           done_d;
    acvs_phase_t    ph;
    acvs_bus_t      bs;
    logic [13:0]    por_cnt;
    logic [7:0]     shreg;
    logic [3:0]     cnt;
    logic [15:0]    tx;
    logic [4:0]     rdcnt;
    logic           rd;
    logic           acked;
    logic           mack;
    logic [15:0]    result;
    logic           rate_slow;
    logic           pend_rate;
    logic           pend_valid;
    acvs_conv_req_t req;
    logic           busy;
    logic           sda_o;
    logic           sda_oe;
  } acvs_core_t;

  // Oscillator domain state
  typedef struct packed {
    logic        rst_m;
    logic        rst_s;
    logic        req_m;
    logic        req_s;
    logic        req_d;
    logic        busy;
    logic        slow;
    logic [18:0] cnt;
    logic        cal;
    logic        done_tgl;
  } acvs_osc_t;

endpackage

/* File: design/acvs_i2c_slave.sv */
// Converter control and I2C slave: power-on wait, conversion sequencing on the
// internal oscillator, result clamping and the serial read/write interface.
// Assumes scl and sda pins are resolved by an external open-drain wire with
// pull-ups, and that adc_sample_i is stable in the core clock domain.
`timescale 1ns/10ps

`include "acvs_params.svh"

module acvs_i2c_slave #(
  parameter int POR_CYC    = `ACVS_POR_CYC,
  parameter int CONV60_CYC = `ACVS_CONV60_CYC,
  parameter int CONV30_CYC = `ACVS_CONV30_CYC
) (
  input  wire logic               core_clk_i,
  input  wire logic               nrst_i,
  input  wire logic               conv_osc_clk_i,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  input  wire logic signed [17:0] adc_sample_i,
  output logic                    sda_o,
  output logic                    sda_oe_o,
  output logic                    conv_busy_o,
  output logic                    slow_rate_o,
  output logic                    offset_cal_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] clamp_code(input logic signed [17:0] raw);
    logic [15:0] res;
    res = raw[15:0];
    if (raw < 18'sh0)
      res = 16'h0000;
    else if (raw > 18'sh0FFFF)
      res = `ACVS_FULL_CODE;
    return res;
  endfunction

  function automatic logic addr_hit(input logic [7:0] b);
    return (b[7:1] == `ACVS_DEV_ADDR) ||
           ((b[7:1] == `ACVS_GCALL_ADDR) && !b[`ACVS_RW_BIT]);
  endfunction

  acvs_pkg::acvs_core_t r_reg;
  acvs_pkg::acvs_core_t r_next;
  acvs_pkg::acvs_osc_t  o_reg;
  acvs_pkg::acvs_osc_t  o_next;

  logic rise_w;
  logic fall_w;
  logic start_w;
  logic stop_w;
  logic done_evt;
  logic new_rate;

  // ------------------------------------------------------------
  // Core domain: pins are oversampled, so 400k/s leaves >30 samples a bit
  // ------------------------------------------------------------
  assign rise_w   = r_reg.scl_s && !r_reg.scl_d;
  assign fall_w   = !r_reg.scl_s && r_reg.scl_d;
  assign start_w  = r_reg.scl_s && r_reg.scl_d && r_reg.sda_d && !r_reg.sda_s;
  assign stop_w   = r_reg.scl_s && r_reg.scl_d && !r_reg.sda_d && r_reg.sda_s;
  assign done_evt = r_reg.done_s ^ r_reg.done_d;
  assign new_rate = r_reg.pend_valid ? r_reg.pend_rate : r_reg.rate_slow;

  always_comb begin
    r_next        = r_reg;
    r_next.scl_m  = scl_i;
    r_next.scl_s  = r_reg.scl_m;
    r_next.scl_d  = r_reg.scl_s;
    r_next.sda_m  = sda_i;
    r_next.sda_s  = r_reg.sda_m;
    r_next.sda_d  = r_reg.sda_s;
    r_next.done_m = o_reg.done_tgl;
    r_next.done_s = r_reg.done_m;
    r_next.done_d = r_reg.done_s;
    r_next.sda_o  = 1'b0;

    unique case (r_reg.ph)
      acvs_pkg::PH_POR: begin
        if (r_reg.por_cnt == 14'(POR_CYC - 1)) begin
          r_next.ph       = acvs_pkg::PH_CONV;
          r_next.req.tgl  = ~r_reg.req.tgl;
          r_next.req.slow = r_reg.rate_slow;
        end else begin
          r_next.por_cnt = r_reg.por_cnt + 14'h0001;
        end
      end
      acvs_pkg::PH_CONV: begin
        if (done_evt) begin
          r_next.result = clamp_code(adc_sample_i);
          r_next.ph     = acvs_pkg::PH_SLEEP;
        end
      end
      acvs_pkg::PH_SLEEP, acvs_pkg::PH_IO: begin
      end
    endcase

    if (stop_w) begin
      r_next.bs     = acvs_pkg::BS_IDLE;
      r_next.sda_oe = 1'b0;
      if (r_reg.ph == acvs_pkg::PH_IO) begin
        r_next.ph         = acvs_pkg::PH_CONV;
        r_next.rate_slow  = new_rate;
        r_next.pend_valid = 1'b0;
        r_next.req.tgl    = ~r_reg.req.tgl;
        r_next.req.slow   = new_rate;
      end
    end else if (start_w) begin
      r_next.bs     = acvs_pkg::BS_ADDR;
      r_next.cnt    = 4'h0;
      r_next.sda_oe = 1'b0;
      if (r_reg.ph != acvs_pkg::PH_IO)
        r_next.pend_valid = 1'b0;
    end else if (rise_w) begin
      unique case (r_reg.bs)
        acvs_pkg::BS_ADDR, acvs_pkg::BS_RX: begin
          r_next.shreg = {r_reg.shreg[6:0], r_reg.sda_s};
          r_next.cnt   = r_reg.cnt + 4'h1;
        end
        acvs_pkg::BS_TACK: r_next.mack = !r_reg.sda_s;
        acvs_pkg::BS_IDLE, acvs_pkg::BS_AACK, acvs_pkg::BS_TX,
        acvs_pkg::BS_RACK, acvs_pkg::BS_IGN: begin
        end
      endcase
    end else if (fall_w) begin
      unique case (r_reg.bs)
        acvs_pkg::BS_ADDR: begin
          if (r_reg.cnt == 4'h8) begin
            r_next.bs    = acvs_pkg::BS_AACK;
            r_next.cnt   = 4'h0;
            r_next.rd    = r_reg.shreg[`ACVS_RW_BIT];
            r_next.acked = 1'b0;
            if (addr_hit(r_reg.shreg) &&
                (r_reg.ph == acvs_pkg::PH_SLEEP || r_reg.ph == acvs_pkg::PH_IO)) begin
              r_next.acked  = 1'b1;
              r_next.sda_oe = 1'b1;
              r_next.ph     = acvs_pkg::PH_IO;
            end
          end
        end
        acvs_pkg::BS_AACK: begin
          if (!r_reg.acked) begin
            r_next.bs     = acvs_pkg::BS_IGN;
            r_next.sda_oe = 1'b0;
          end else if (r_reg.rd) begin
            r_next.bs     = acvs_pkg::BS_TX;
            r_next.sda_oe = !r_reg.result[`ACVS_MSB];
            r_next.tx     = {r_reg.result[14:0], 1'b0};
            r_next.rdcnt  = 5'h01;
          end else begin
            r_next.bs     = acvs_pkg::BS_RX;
            r_next.sda_oe = 1'b0;
          end
        end
        acvs_pkg::BS_TX: begin
          if (r_reg.rdcnt[2:0] == 3'h0) begin
            r_next.bs     = acvs_pkg::BS_TACK;
            r_next.sda_oe = 1'b0;
            if (r_reg.rdcnt == 5'h10) begin
              r_next.ph         = acvs_pkg::PH_CONV;
              r_next.rate_slow  = new_rate;
              r_next.pend_valid = 1'b0;
              r_next.req.tgl    = ~r_reg.req.tgl;
              r_next.req.slow   = new_rate;
            end
          end else begin
            r_next.sda_oe = !r_reg.tx[`ACVS_MSB];
            r_next.tx     = {r_reg.tx[14:0], 1'b0};
            r_next.rdcnt  = r_reg.rdcnt + 5'h01;
          end
        end
        acvs_pkg::BS_TACK: begin
          if (r_reg.mack && r_reg.rdcnt != 5'h10) begin
            r_next.bs     = acvs_pkg::BS_TX;
            r_next.sda_oe = !r_reg.tx[`ACVS_MSB];
            r_next.tx     = {r_reg.tx[14:0], 1'b0};
            r_next.rdcnt  = r_reg.rdcnt + 5'h01;
          end else begin
            r_next.bs = acvs_pkg::BS_IGN;
          end
        end
        acvs_pkg::BS_RX: begin
          if (r_reg.cnt == 4'h8) begin
            r_next.pend_rate  = r_reg.shreg[`ACVS_RATE_BIT];
            r_next.pend_valid = 1'b1;
            r_next.sda_oe     = 1'b1;
            r_next.bs         = acvs_pkg::BS_RACK;
          end
        end
        acvs_pkg::BS_RACK: begin
          // Only one configuration byte; any further byte is not acknowledged
          r_next.sda_oe = 1'b0;
          r_next.bs     = acvs_pkg::BS_IGN;
        end
        acvs_pkg::BS_IDLE, acvs_pkg::BS_IGN: begin
        end
      endcase
    end

    r_next.busy = (r_next.ph == acvs_pkg::PH_CONV) || (r_next.ph == acvs_pkg::PH_POR);
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      r_reg            <= '0;
      r_reg.ph         <= acvs_pkg::PH_POR;
      r_reg.bs         <= acvs_pkg::BS_IDLE;
      r_reg.scl_m      <= 1'b1;
      r_reg.scl_s      <= 1'b1;
      r_reg.scl_d      <= 1'b1;
      r_reg.sda_m      <= 1'b1;
      r_reg.sda_s      <= 1'b1;
      r_reg.sda_d      <= 1'b1;
      r_reg.rate_slow  <= `ACVS_RATE_RST;
      r_reg.busy       <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------
  // Oscillator domain: conversion timer
  // ------------------------------------------------------------
  // req.slow is held stable from the toggle until the next request,
  // so it is safe to read once the toggle has been synchronised.
  always_comb begin
    o_next       = o_reg;
    o_next.rst_m = nrst_i;
    o_next.rst_s = o_reg.rst_m;
    o_next.req_m = r_reg.req.tgl;
    o_next.req_s = o_reg.req_m;
    o_next.req_d = o_reg.req_s;
    if (!o_reg.rst_s) begin
      o_next.req_m    = 1'b0;
      o_next.req_s    = 1'b0;
      o_next.req_d    = 1'b0;
      o_next.busy     = 1'b0;
      o_next.slow     = 1'b0;
      o_next.cnt      = 19'h00000;
      o_next.cal      = 1'b0;
      o_next.done_tgl = 1'b0;
    end else if (o_reg.req_s ^ o_reg.req_d) begin
      o_next.busy = 1'b1;
      o_next.slow = r_reg.req.slow;
      o_next.cnt  = 19'h00000;
    end else if (o_reg.busy) begin
      if (o_reg.cnt == (o_reg.slow ? 19'(CONV30_CYC - 1) : 19'(CONV60_CYC - 1))) begin
        o_next.busy     = 1'b0;
        o_next.done_tgl = ~o_reg.done_tgl;
      end else begin
        o_next.cnt = o_reg.cnt + 19'h00001;
      end
    end
    // First half of a slow conversion is spent on offset calibration
    o_next.cal = o_next.busy && o_next.slow &&
                 (o_next.cnt < 19'(CONV30_CYC / 2));
  end

  always_ff @(posedge conv_osc_clk_i) begin
    o_reg <= o_next;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign sda_o        = r_reg.sda_o;
  assign sda_oe_o     = r_reg.sda_oe;
  assign conv_busy_o  = r_reg.busy;
  assign slow_rate_o  = r_reg.rate_slow;
  assign offset_cal_o = o_reg.cal;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_nack_busy;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (r_reg.bs == acvs_pkg::BS_ADDR && fall_w && r_reg.cnt == 4'h8 && r_reg.busy)
      |=> !sda_oe_o [*2];
  endproperty
  a_nack_busy: assert property (p_nack_busy) else $error("acked while converting");

  property p_open_drain;
    @(posedge core_clk_i) disable iff (!nrst_i)
    sda_oe_o |-> !sda_o && r_reg.ph == acvs_pkg::PH_IO;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven outside io");

  property p_change_on_fall;
    @(posedge core_clk_i) disable iff (!nrst_i)
    $changed(sda_oe_o) |-> $past(fall_w) || $past(stop_w) || $past(start_w);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall) else $error("sda moved off fall");

  property p_stop_conv;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (stop_w && r_reg.ph == acvs_pkg::PH_IO) |=> r_reg.ph == acvs_pkg::PH_CONV && conv_busy_o;
  endproperty
  a_stop_conv: assert property (p_stop_conv) else $error("stop did not start conversion");

  property p_conv_sleep;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (r_reg.ph == acvs_pkg::PH_CONV && done_evt) |=> r_reg.ph == acvs_pkg::PH_SLEEP ##1 !conv_busy_o;
  endproperty
  a_conv_sleep: assert property (p_conv_sleep) else $error("no sleep after conversion");

  property p_hold_result;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (r_reg.ph == acvs_pkg::PH_SLEEP) |=> $stable(r_reg.result);
  endproperty
  a_hold_result: assert property (p_hold_result) else $error("result moved in sleep");

  property p_rate_apply;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (stop_w && r_reg.ph == acvs_pkg::PH_IO && r_reg.pend_valid)
      |=> slow_rate_o == $past(r_reg.pend_rate);
  endproperty
  a_rate_apply: assert property (p_rate_apply) else $error("rate not applied");

  property p_clamp_low;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (r_reg.ph == acvs_pkg::PH_CONV && done_evt && adc_sample_i[17]) |=> r_reg.result == 16'h0000;
  endproperty
  a_clamp_low: assert property (p_clamp_low) else $error("negative input not clamped");

  property p_msb_first;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (r_reg.bs == acvs_pkg::BS_AACK && fall_w && r_reg.acked && r_reg.rd)
      |=> sda_oe_o == !$past(r_reg.result[15]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb not first");

  property p_cal_slow;
    @(posedge conv_osc_clk_i) disable iff (!o_reg.rst_s)
    offset_cal_o |-> o_reg.slow && o_reg.busy;
  endproperty
  a_cal_slow: assert property (p_cal_slow) else $error("calibration at fast rate");

  c_read_all: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    r_reg.bs == acvs_pkg::BS_TX && fall_w && r_reg.rdcnt == 5'h10);
  c_config: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    r_reg.bs == acvs_pkg::BS_RACK && r_reg.pend_rate);
  c_busy_nack: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    r_reg.bs == acvs_pkg::BS_AACK && !r_reg.acked && r_reg.busy);

endmodule // acvs_i2c_slave

/* File: bench/acvs_i2c_master.sv */
// Behavioural I2C bus master that faces the converter slave.
// Assumes the bench resolves SDA from all pull-down enables plus a pull-up.
`timescale 1ns/10ps
module acvs_i2c_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // SCL low 1.32 us, high 0.64 us in core cycles: just inside fast mode
  localparam int T_LOW  = 33;
  localparam int T_HIGH = 16;

  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  // One clock pulse; a released line reads the pull-up, never a stale value
  task automatic pulse(input logic b, output logic s);
    tick(8);
    sda_low_o = !b;
    tick(T_LOW - 8);
    scl_o = 1'b1;
    tick(T_HIGH / 2);
    s = sda_i;
    tick(T_HIGH / 2);
    scl_o = 1'b0;
  endtask

  // Also serves as repeated start: SDA is released while SCL is still low
  task automatic start();
    tick(8);
    sda_low_o = 1'b0;
    tick(8);
    scl_o = 1'b1;
    tick(T_HIGH);
    sda_low_o = 1'b1;
    tick(T_HIGH);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    tick(8);
    sda_low_o = 1'b1;
    tick(T_LOW);
    scl_o = 1'b1;
    tick(T_HIGH);
    sda_low_o = 1'b0;
    tick(T_LOW);
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(d[i], s);
    pulse(1'b1, s);
    ack = !s;
  endtask

  task automatic recv(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, s);
      d[i] = s;
    end
    pulse(nack, s);
  endtask
endmodule // acvs_i2c_master

/* File: bench/test_adc_conversion_i2c_slave.sv */
// Self-checking bench for the converter I2C slave.
// Assumes the master model above and shortened power-on and conversion counts.
`timescale 1ns/10ps
module test_adc_conversion_i2c_slave;
  logic               core_clk;
  logic               osc_clk;
  logic               nrst;
  logic signed [17:0] sample;
  logic               sda_o, sda_oe, busy, slow, cal, scl, m_low;
  wire                sda = !((sda_oe && !sda_o) || m_low);
  int                 err_total, n_tests, busy_len;
  bit                 cal_seen;

  acvs_i2c_slave #(.POR_CYC(20), .CONV60_CYC(200), .CONV30_CYC(400)) uut (
    .core_clk_i(core_clk), .nrst_i(nrst), .conv_osc_clk_i(osc_clk), .scl_i(scl),
    .sda_i(sda), .adc_sample_i(sample), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .conv_busy_o(busy), .slow_rate_o(slow), .offset_cal_o(cal));
  acvs_i2c_master m (.clk_i(core_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    osc_clk = 1'b0;
    #7;
    forever #40 osc_clk = ~osc_clk;
  end

  // Length of the current busy stretch and whether calibration showed in it,
  // so a probe that eats the first half of a conversion does not hide either
  always @(posedge core_clk) begin
    busy_len <= (busy === 1'b1) ? busy_len + 1 : 0;
    cal_seen <= (busy === 1'b1) && (cal_seen || cal === 1'b1);
  end

  task automatic finish_test();
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      $display("BAD %0t %s", $time, msg);
      err_total++;
    end
  endtask

  task automatic addr(input logic [6:0] a, input logic rw, output logic ack);
    m.start();
    m.send({a, rw}, ack);
  endtask

  // Bounded wait for the end of a conversion; a hang ends the run
  task automatic wait_idle(input int lo, input int hi, input logic exp_cal);
    int k, last;
    logic seen;
    k = 0;
    last = 0;
    seen = 1'b0;
    while (busy !== 1'b0 && k < 3000) begin
      last = busy_len;
      seen = cal_seen;
      m.tick(1);
      k++;
    end
    chk(last >= lo && last <= hi, "conversion length");
    chk(seen === exp_cal, "offset calibration flag");
    if (k >= 3000) begin
      chk(1'b0, "conversion did not end");
      finish_test();
    end
  endtask

  // Mid-run reset clears the written rate and restarts the power-on sequence
  task automatic t_reset_mid();
    nrst = 1'b0;
    m.tick(10);
    chk(busy === 1'b1 && slow === 1'b0 && sda_oe === 1'b0, "mid-run reset state");
    nrst = 1'b1;
    wait_idle(420, 480, 1'b0);
    chk(slow === 1'b0, "rate after mid-run reset");
  endtask

  task automatic probe_nack();
    logic ack;
    addr(7'h14, 1'b1, ack);
    chk(ack === 1'b0, "address acknowledged while converting");
    m.stop();
  endtask

  task automatic t_refuse();
    logic ack;
    logic [7:0] bad [4] = '{8'h2A, 8'hA8, 8'h08, 8'hEF};
    for (int i = 0; i < 4; i++) begin
      addr(bad[i][7:1], bad[i][0], ack);
      chk(ack === 1'b0, "foreign address acknowledged");
      m.stop();
    end
    chk(busy === 1'b0, "refused frame started a conversion");
    chk(sda_oe === 1'b0, "data line held after refused frame");
  endtask

  task automatic read16(input logic signed [17:0] nxt, input logic [15:0] exp);
    logic [7:0] hb, lb;
    m.recv(1'b0, hb);
    sample = nxt;
    m.recv(1'b1, lb);
    chk({hb, lb} === exp, "read data");
    chk(busy === 1'b1, "no conversion after 16 bits");
    m.stop();
  endtask

  task automatic t_read(input logic [15:0] exp, input logic signed [17:0] nxt,
                        input int lo, input int hi, input logic exp_cal);
    logic ack;
    addr(7'h14, 1'b1, ack);
    chk(ack === 1'b1, "read address refused");
    read16(nxt, exp);
    wait_idle(lo, hi, exp_cal);
  endtask

  task automatic t_write_slow();
    logic ack;
    addr(7'h14, 1'b0, ack);
    chk(ack === 1'b1, "write address refused");
    m.send(8'h01, ack);
    chk(ack === 1'b1, "configuration byte refused");
    m.stop();
    chk(busy === 1'b1, "stop after write did not convert");
    chk(slow === 1'b1, "slow rate not taken");
    probe_nack();
    wait_idle(800, 840, 1'b1);
  endtask

  task automatic t_gcall();
    logic ack;
    addr(7'h77, 1'b0, ack);
    chk(ack === 1'b1, "global address refused");
    m.stop();
    chk(busy === 1'b1 && slow === 1'b1, "global call stop");
    probe_nack();
    wait_idle(800, 840, 1'b1);
  endtask

  // Write then repeated start and read; only bit 0 of the byte picks the rate
  task automatic t_wr_sr_rd(input logic [15:0] exp);
    logic ack;
    addr(7'h14, 1'b0, ack);
    m.send(8'hFE, ack);
    chk(ack === 1'b1, "fast configuration byte refused");
    m.send(8'h01, ack);
    chk(ack === 1'b0, "second configuration byte acknowledged");
    addr(7'h14, 1'b1, ack);
    chk(ack === 1'b1, "read after repeated start refused");
    read16(18'sh00000, exp);
    chk(slow === 1'b0, "fast rate not taken");
    wait_idle(400, 430, 1'b0);
  endtask

  initial begin
    nrst = 1'b0;
    sample = 18'sh0A5C3;
    err_total = 0;
    n_tests = 0;
    repeat (10) @(posedge core_clk);
    #2;
    chk(busy === 1'b1 && slow === 1'b0 && sda_oe === 1'b0, "reset state");
    nrst = 1'b1;
    wait_idle(420, 480, 1'b0);
    chk(slow === 1'b0, "default rate");
    t_refuse();
    m.tick(300);
    chk(busy === 1'b0, "sleep left without request");
    t_read(16'hA5C3, -18'sd5, 400, 430, 1'b0);
    t_read(16'h0000, 18'sh1FFFF, 400, 430, 1'b0);
    t_read(16'hFFFF, 18'sh01234, 400, 430, 1'b0);
    t_write_slow();
    t_read(16'h1234, 18'sh0FFFF, 800, 840, 1'b1);
    t_gcall();
    t_reset_mid();
    t_wr_sr_rd(16'hFFFF);
    finish_test();
  end
endmodule // test_adc_conversion_i2c_slave
